// ---- core/nibio_cfg.svh ----
// register map, field positions and option encodings for the nibble port block
`ifndef NIBIO_CFG_SVH
`define NIBIO_CFG_SVH

`define NIBIO_OFS_PORT_A     8'h00
`define NIBIO_OFS_PORT_C     8'h04
`define NIBIO_OFS_PORT_D     8'h08
`define NIBIO_OFS_PORT_E     8'h0c
`define NIBIO_OFS_BITOP      8'h10
`define NIBIO_OFS_STATUS     8'h14
`define NIBIO_OFS_HALT       8'h18

`define NIBIO_BITOP_PORT_LSB 0
`define NIBIO_BITOP_BIT_LSB  2
`define NIBIO_BITOP_OP_LSB   4

`define NIBIO_ST_TEST_BIT    0
`define NIBIO_ST_HALTED_BIT  1
`define NIBIO_ST_DIV_LSB     2
`define NIBIO_ST_CMP_BIT     4

`define NIBIO_DIV_SEL_1      2'h0
`define NIBIO_DIV_SEL_3      2'h1
`define NIBIO_DIV_SEL_4      2'h2
`define NIBIO_DIV_RATIO_1    3'h1
`define NIBIO_DIV_RATIO_3    3'h3
`define NIBIO_DIV_RATIO_4    3'h4

`define NIBIO_OUT_RESET      4'hf
`define NIBIO_RESET_LOW_CYC  4

`endif

// ---- core/nibio_pkg.sv ----
// types shared by the nibble port block
package nibio_pkg;
    typedef enum logic [1:0] {
        NIBIO_PORT_A,
        NIBIO_PORT_C,
        NIBIO_PORT_D,
        NIBIO_PORT_E
    } nibio_port_t;

    typedef enum logic [1:0] {
        NIBIO_OP_TEST_SET,
        NIBIO_OP_TEST_CLEAR,
        NIBIO_OP_SET,
        NIBIO_OP_CLEAR
    } nibio_op_t;

    typedef enum logic {
        NIBIO_RUN,
        NIBIO_HALTED
    } nibio_state_t;
endpackage

// ---- core/nibio_clkdiv.sv ----
// system clock enable divider, ratio 1, 3 or 4
`timescale 1ns/1ps
`default_nettype none
`include "nibio_cfg.svh"

module nibio_clkdiv
    import nibio_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // ratio option
    input  wire logic [1:0] div_sel,
    // enable out
    output logic            sys_ce
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] ratio;

    assign ratio = (div_sel == `NIBIO_DIV_SEL_1) ? `NIBIO_DIV_RATIO_1 :
                   (div_sel == `NIBIO_DIV_SEL_3) ? `NIBIO_DIV_RATIO_3 : `NIBIO_DIV_RATIO_4;
    assign sys_ce   = (cnt_reg == ratio - 3'h1);
    assign cnt_next = sys_ce ? 3'h0 : cnt_reg + 3'h1;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ---- core/nibio_top.sv ----
// nibble port block: three open-drain ports, one input/comparator port, wishbone slave
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "nibio_cfg.svh"

module nibio_top
    import nibio_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // static options
    input  wire logic        opt_c_reset_high,
    input  wire logic        opt_d_reset_high,
    input  wire logic        opt_cmp_mode,
    input  wire logic [1:0]  opt_div_sel,
    // first port (bit 3 is standby_control_pin)
    input  wire logic [3:0]  first_port_in,
    output logic [3:0]       first_port_out,
    output logic [3:0]       first_port_oe,
    // second port
    input  wire logic [3:0]  second_port_in,
    output logic [3:0]       second_port_out,
    output logic [3:0]       second_port_oe,
    // third port
    input  wire logic [3:0]  third_port_in,
    output logic [3:0]       third_port_out,
    output logic [3:0]       third_port_oe,
    // input-only port and comparator front end (digitised levels)
    input  wire logic [3:0]  input_port_in,
    input  wire logic [3:0]  comparator_in0,
    input  wire logic [3:0]  comparator_in1,
    input  wire logic [3:0]  comparator_in2,
    input  wire logic [3:0]  comparator_in3,
    input  wire logic [3:0]  reference_in_low_pair,
    input  wire logic [3:0]  reference_in_high_pair,
    // state
    output logic             halted
);
    function automatic logic cmp_above(input logic [3:0] lvl, input logic [3:0] ref_lvl);
        cmp_above = (lvl > ref_lvl);
    endfunction

    logic         sys_ce;
    logic [3:0]   pa_reg;
    logic [3:0]   pc_reg;
    logic [3:0]   pd_reg;
    logic [3:0]   pa_next;
    logic [3:0]   pc_next;
    logic [3:0]   pd_next;
    logic         started_reg;
    logic         test_reg;
    logic         test_next;
    logic         ack_reg;
    logic [31:0]  dat_reg;
    logic [31:0]  dat_next;
    nibio_state_t state_reg;
    nibio_state_t state_next;

    // bit-op instruction fields
    nibio_port_t  op_port;
    nibio_op_t    op_kind;
    logic [1:0]   op_bit;
    logic [3:0]   op_mask;
    logic [3:0]   op_nibble;
    logic         op_sel_bit;

    wire        req      = wb_cyc_i & wb_stb_i;
    wire        exec     = req & sys_ce & ~ack_reg;
    wire        wr_ok    = exec & wb_we_i & wb_sel_i[0] & (state_reg == NIBIO_RUN);
    wire        wr_a     = wr_ok & (wb_adr_i == `NIBIO_OFS_PORT_A);
    wire        wr_c     = wr_ok & (wb_adr_i == `NIBIO_OFS_PORT_C);
    wire        wr_d     = wr_ok & (wb_adr_i == `NIBIO_OFS_PORT_D);
    wire        wr_bitop = wr_ok & (wb_adr_i == `NIBIO_OFS_BITOP);
    wire        wr_halt  = wr_ok & (wb_adr_i == `NIBIO_OFS_HALT);
    wire        standby  = first_port_in[3];

    // comparator or plain pins, fixed by a strap
    wire [3:0]  cmp_vec  = {cmp_above(comparator_in3, reference_in_high_pair),
                            cmp_above(comparator_in2, reference_in_high_pair),
                            cmp_above(comparator_in1, reference_in_low_pair),
                            cmp_above(comparator_in0, reference_in_low_pair)};
    wire [3:0]  pe_val   = opt_cmp_mode ? cmp_vec : input_port_in;

    // levels on pins: before the first clock after reset the option levels show
    wire [3:0]  pc_level = started_reg ? pc_reg : {4{opt_c_reset_high}};
    wire [3:0]  pd_level = started_reg ? pd_reg : {4{opt_d_reset_high}};

    assign op_port    = nibio_port_t'(wb_dat_i[`NIBIO_BITOP_PORT_LSB +: 2]);
    assign op_bit     = wb_dat_i[`NIBIO_BITOP_BIT_LSB +: 2];
    assign op_kind    = nibio_op_t'(wb_dat_i[`NIBIO_BITOP_OP_LSB +: 2]);
    assign op_mask    = 4'h1 << op_bit;
    // tests look at pin levels, never the output registers
    assign op_nibble  = (op_port == NIBIO_PORT_A) ? first_port_in :
                        (op_port == NIBIO_PORT_C) ? second_port_in :
                        (op_port == NIBIO_PORT_D) ? third_port_in : pe_val;
    assign op_sel_bit = op_nibble[op_bit];

    wire        op_set   = wr_bitop & (op_kind == NIBIO_OP_SET);
    wire        op_clr   = wr_bitop & (op_kind == NIBIO_OP_CLEAR);
    wire        op_test  = wr_bitop & ((op_kind == NIBIO_OP_TEST_SET) | (op_kind == NIBIO_OP_TEST_CLEAR));

    // one masked update per port; the input-only port has no register
    function automatic logic [3:0] port_update(input logic [3:0] cur, input logic wr_nib, input logic hit,
                                               input logic [3:0] nib, input logic set, input logic clr,
                                               input logic [3:0] mask);
        port_update = wr_nib      ? nib :
                      (hit & set) ? (cur | mask) :
                      (hit & clr) ? (cur & ~mask) : cur;
    endfunction

    assign pa_next = port_update(pa_reg, wr_a, op_port == NIBIO_PORT_A, wb_dat_i[3:0],
                                 op_set, op_clr, op_mask);
    assign pc_next = port_update(pc_reg, wr_c, op_port == NIBIO_PORT_C, wb_dat_i[3:0],
                                 op_set, op_clr, op_mask);
    assign pd_next = port_update(pd_reg, wr_d, op_port == NIBIO_PORT_D, wb_dat_i[3:0],
                                 op_set, op_clr, op_mask);

    // branch decision: taken when the bit matches the sense of the
    assign test_next = op_test ? (op_sel_bit ^ (op_kind == NIBIO_OP_TEST_CLEAR)) : test_reg;

    // standby: halt is entered only while the control pin is high, left when it falls
    // the pin is not debounced here, so bounce in the halt cycle would be taken as-is
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NIBIO_RUN: begin
                if (wr_halt && standby) begin
                    state_next = NIBIO_HALTED;
                end
            end
            NIBIO_HALTED: begin
                if (!standby) begin
                    state_next = NIBIO_RUN;
                end
            end
            default: begin
                state_next = NIBIO_RUN;
            end
        endcase
    end

    // reads sample the pins at the executing edge
    always_comb begin
        dat_next = 32'h0;
        case (wb_adr_i)
            `NIBIO_OFS_PORT_A: dat_next[3:0] = first_port_in;
            `NIBIO_OFS_PORT_C: dat_next[3:0] = second_port_in;
            `NIBIO_OFS_PORT_D: dat_next[3:0] = third_port_in;
            `NIBIO_OFS_PORT_E: dat_next[3:0] = pe_val;
            `NIBIO_OFS_STATUS: begin
                dat_next[`NIBIO_ST_TEST_BIT]      = test_reg;
                dat_next[`NIBIO_ST_HALTED_BIT]    = (state_reg == NIBIO_HALTED);
                dat_next[`NIBIO_ST_DIV_LSB +: 2]  = opt_div_sel;
                dat_next[`NIBIO_ST_CMP_BIT]       = opt_cmp_mode;
            end
            default: dat_next = 32'h0;
        endcase
    end

    // every instruction waits for a system clock enable
    nibio_clkdiv u_div (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .div_sel (opt_div_sel),
        .sys_ce  (sys_ce)
    );

    // asynchronous reset restarts everything at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pa_reg      <= `NIBIO_OUT_RESET;
            pc_reg      <= `NIBIO_OUT_RESET;
            pd_reg      <= `NIBIO_OUT_RESET;
            started_reg <= 1'b0;
            test_reg    <= 1'b0;
            state_reg   <= NIBIO_RUN;
        end else begin
            pa_reg      <= pa_next;
            pc_reg      <= started_reg ? pc_next : {4{opt_c_reset_high}};
            pd_reg      <= started_reg ? pd_next : {4{opt_d_reset_high}};
            started_reg <= 1'b1;
            test_reg    <= test_next;
            state_reg   <= state_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= exec;
            dat_reg <= exec ? dat_next : dat_reg;
        end
    end

    // open drain: pins are only ever pulled low
    assign first_port_out  = 4'h0;
    assign second_port_out = 4'h0;
    assign third_port_out  = 4'h0;
    assign first_port_oe   = ~pa_reg;
    assign second_port_oe  = ~pc_level;
    assign third_port_oe   = ~pd_level;
    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = dat_reg;
    assign halted          = (state_reg == NIBIO_HALTED);

    // checks on port, standby, divider and bus behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // instruction enable spacing for the two slow ratios
    sequence s_ce_gap3;
        !sys_ce [*3] ##1 sys_ce;
    endsequence

    sequence s_ce_gap2;
        !sys_ce [*2] ##1 sys_ce;
    endsequence

    a_nibble_out_a: assert property (wr_a |=> first_port_oe == ~$past(wb_dat_i[3:0]))
        else $error("nibble write did not reach first port");
    a_nibble_read: assert property (exec && !wb_we_i && wb_adr_i == `NIBIO_OFS_PORT_C
                                    |=> wb_ack_o && wb_dat_o[3:0] == $past(second_port_in))
        else $error("nibble read returned wrong pin levels");
    a_bit_test_set: assert property (wr_bitop && op_kind == NIBIO_OP_TEST_SET
                                     |=> test_reg == $past(op_sel_bit))
        else $error("bit test decision wrong");
    a_bit_test_clear: assert property (wr_bitop && op_kind == NIBIO_OP_TEST_CLEAR
                                       |=> test_reg == !$past(op_sel_bit))
        else $error("bit clear test decision wrong");
    a_bit_op_keep: assert property (op_set && op_port == NIBIO_PORT_C && started_reg
                                    |=> ((pc_reg ^ $past(pc_reg)) & ~$past(op_mask)) == 4'h0
                                        && (pc_reg & $past(op_mask)) != 4'h0)
        else $error("bit set disturbed other bits");
    a_bit_clr_keep: assert property (op_clr && op_port == NIBIO_PORT_D && started_reg
                                     |=> ((pd_reg ^ $past(pd_reg)) & ~$past(op_mask)) == 4'h0
                                         && (pd_reg & $past(op_mask)) == 4'h0)
        else $error("bit clear disturbed other bits");
    a_port_hold: assert property (!wr_a && !wr_bitop |=> $stable(pa_reg))
        else $error("first port output changed without a write");
    a_standby_entry: assert property (wr_halt && standby |=> halted)
        else $error("standby not entered");
    a_standby_hold: assert property (halted && standby |=> halted)
        else $error("standby left while control pin high");
    a_standby_exit: assert property (halted && !standby |=> !halted)
        else $error("standby kept after control pin fell");
    a_halt_no_write: assert property (exec && wb_we_i && halted |=> $stable(pa_reg))
        else $error("write took effect while halted");
    a_no_standby_c: assert property (wr_halt && !standby |=> !halted)
        else $error("halt entered without the first port control pin");
    a_reset_level_c: assert property (!started_reg |-> second_port_oe == {4{~opt_c_reset_high}})
        else $error("second port reset level wrong");
    a_reset_level_d: assert property ($rose(started_reg) |-> third_port_oe == {4{~opt_d_reset_high}})
        else $error("third port level after reset wrong");
    a_reset_sep_d: assert property (!started_reg |-> third_port_oe == {4{~opt_d_reset_high}})
        else $error("third port level in reset wrong");
    a_reset_restart: assert property ($rose(started_reg) |-> first_port_oe == 4'h0 && !halted)
        else $error("restart state wrong");
    a_plain_input: assert property (exec && !wb_we_i && wb_adr_i == `NIBIO_OFS_PORT_E
                                    && !opt_cmp_mode |=> wb_dat_o[3:0] == $past(input_port_in))
        else $error("plain input read wrong");
    a_cmp_result: assert property (exec && !wb_we_i && wb_adr_i == `NIBIO_OFS_PORT_E
                                   && opt_cmp_mode |=> wb_dat_o[3:0] == $past(cmp_vec))
        else $error("comparator read wrong");
    a_div_by_one: assert property (opt_div_sel == `NIBIO_DIV_SEL_1 |-> sys_ce)
        else $error("divide by one enable missing");
    a_div_by_three: assert property (sys_ce && opt_div_sel == `NIBIO_DIV_SEL_3 && $stable(opt_div_sel)
                                     |=> s_ce_gap2)
        else $error("divide by three spacing wrong");
    a_div_by_four: assert property (sys_ce && opt_div_sel == `NIBIO_DIV_SEL_4 && $stable(opt_div_sel)
                                    |=> s_ce_gap3)
        else $error("divide by four spacing wrong");
    a_drain_only: assert property ((first_port_out | second_port_out | third_port_out) == 4'h0)
        else $error("port drove high");
    a_ack_release: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule
`default_nettype wire

// ---- tb/nibio_keys.sv ----
// key contacts and pull-up seen by one open-drain nibble port
`timescale 1ns/1ps
`default_nettype none

module nibio_keys (
    // port driver
    input  wire logic [3:0] port_out,
    input  wire logic [3:0] port_oe,
    // contacts, high = key pressed to ground
    input  wire logic [3:0] key_down,
    // wire level
    output logic      [3:0] pin
);
    // released and unpressed pins float up to the pull-up
    // keys arrive debounced, so the standby pin never chatters during a halt
    assign pin = ~(port_oe & ~port_out) & ~key_down;
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the nibble port block
`timescale 1ns/1ps
`default_nettype none
`include "nibio_cfg.svh"

module testbench;
    import nibio_pkg::*;
    logic        mclk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, halted;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat, wb_rdat, x;
    logic        opt_c, opt_d, opt_cmp;
    logic [1:0]  opt_div;
    logic [3:0]  a_out, a_oe, a_pin, a_key, c_out, c_oe, c_pin, d_out, d_oe, d_pin;
    logic [3:0]  e_in, cin0, cin1, cin2, cin3, ref_lo, ref_hi;
    int          fail_count, n_tests;
    int          cyc_no = 0;
    int          t_ack;

    nibio_top nibio_top_inst (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .opt_c_reset_high(opt_c), .opt_d_reset_high(opt_d), .opt_cmp_mode(opt_cmp),
        .opt_div_sel(opt_div), .first_port_in(a_pin), .first_port_out(a_out), .first_port_oe(a_oe),
        .second_port_in(c_pin), .second_port_out(c_out), .second_port_oe(c_oe), .third_port_in(d_pin),
        .third_port_out(d_out), .third_port_oe(d_oe), .input_port_in(e_in), .comparator_in0(cin0),
        .comparator_in1(cin1), .comparator_in2(cin2), .comparator_in3(cin3),
        .reference_in_low_pair(ref_lo), .reference_in_high_pair(ref_hi), .halted(halted));

    // only the first port has keys; the other two sit on bare pull-ups
    nibio_keys keys_a (.port_out(a_out), .port_oe(a_oe), .key_down(a_key), .pin(a_pin));
    nibio_keys keys_c (.port_out(c_out), .port_oe(c_oe), .key_down(4'h0), .pin(c_pin));
    nibio_keys keys_d (.port_out(d_out), .port_oe(d_oe), .key_down(4'h0), .pin(d_pin));

    // edge count, used to measure the spacing of answers
    always @(posedge mclk) cyc_no <= cyc_no + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack !== 1'b1 && n < 200);
        if (wb_ack !== 1'b1) fail_count++;
        t_ack = cyc_no;
        x = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        repeat (4) @(posedge mclk);  // let pin changes settle between transfers
        wb(1'b0, a, 32'h0);
        chk(x, exp);
    endtask

    task automatic do_reset(input logic c, input logic d, input logic cmp, input logic [1:0] div);
        @(posedge mclk);
        rst_n   <= 1'b0;
        opt_c   <= c;
        opt_d   <= d;
        opt_cmp <= cmp;
        opt_div <= div;
        repeat (16) @(posedge mclk);  // held well past the four-clock minimum
        chk({a_oe, c_oe, d_oe}, {4'h0, {4{~c}}, {4{~d}}});
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_reset_levels;
        chk({a_oe, c_oe, d_oe}, 12'h0f0);
        chk({a_out, c_out, d_out}, 12'h000);
    endtask

    task automatic t_nibble;
        wb(1'b1, `NIBIO_OFS_PORT_A, 32'h5);
        chk(a_oe, 4'ha);
        rd(`NIBIO_OFS_PORT_A, 32'h5);
        a_key <= 4'h1;
        rd(`NIBIO_OFS_PORT_A, 32'h4);
        chk(a_oe, 4'ha);
    endtask

    task automatic t_bitops;
        wb(1'b1, `NIBIO_OFS_PORT_C, 32'h0);
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h29);
        chk(c_oe, 4'hb);
        wb(1'b1, `NIBIO_OFS_PORT_D, 32'hf);
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h32);
        chk(d_oe, 4'h1);
        rd(`NIBIO_OFS_PORT_C, 32'h4);
    endtask

    task automatic t_tests;
        // first port pins now read 4: bit 2 high, bit 0 held low by a key
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h08);
        rd(`NIBIO_OFS_STATUS, 32'h1);
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h00);
        rd(`NIBIO_OFS_STATUS, 32'h0);
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h10);
        rd(`NIBIO_OFS_STATUS, 32'h1);
        e_in <= 4'h9;
        rd(`NIBIO_OFS_PORT_E, 32'h9);
        wb(1'b1, `NIBIO_OFS_BITOP, 32'h0f);
        rd(`NIBIO_OFS_STATUS, 32'h1);
    endtask

    task automatic t_halt;
        int n;
        a_key <= 4'h0;
        wb(1'b1, `NIBIO_OFS_PORT_C, 32'hf);
        wb(1'b1, `NIBIO_OFS_HALT, 32'h0);
        chk(halted, 1'b0);
        wb(1'b1, `NIBIO_OFS_PORT_A, 32'hf);
        repeat (4) @(posedge mclk);
        wb(1'b1, `NIBIO_OFS_HALT, 32'h0);
        @(posedge mclk);
        chk(halted, 1'b1);
        wb(1'b1, `NIBIO_OFS_PORT_A, 32'h0);
        chk(a_oe, 4'h0);
        a_key <= 4'h8;
        n = 0;
        while (halted !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        chk(halted, 1'b0);
        a_key <= 4'h0;
    endtask

    // answers to back-to-back requests are one divider period apart at ratios 3 and 4
    task automatic t_spacing(input int ratio);
        int t0;
        wb(1'b0, `NIBIO_OFS_STATUS, 32'h0);
        t0 = t_ack;
        wb(1'b0, `NIBIO_OFS_STATUS, 32'h0);
        chk(t_ack - t0, ratio);
    endtask

    task automatic t_second_reset;
        wb(1'b1, `NIBIO_OFS_PORT_A, 32'h0);
        wb(1'b1, `NIBIO_OFS_PORT_C, 32'h0);
        cin0   <= 4'h5;
        cin1   <= 4'h2;
        cin2   <= 4'h9;
        cin3   <= 4'h1;
        ref_lo <= 4'h3;
        ref_hi <= 4'h4;
        do_reset(1'b1, 1'b0, 1'b1, `NIBIO_DIV_SEL_3);
        chk({a_oe, c_oe, d_oe}, 12'h00f);
        rd(`NIBIO_OFS_PORT_E, 32'h5);
        rd(`NIBIO_OFS_STATUS, 32'h14);
        rd(8'h40, 32'h0);
        t_spacing(3);
    endtask

    task automatic t_div_four;
        do_reset(1'b0, 1'b0, 1'b0, `NIBIO_DIV_SEL_4);
        chk({a_oe, c_oe, d_oe}, 12'h0ff);
        t_spacing(4);
        rd(`NIBIO_OFS_STATUS, 32'h8);
    endtask

    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        end_sim;
    end

    initial begin
        {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        wb_sel = 4'hf;
        {opt_c, opt_d, opt_cmp, opt_div} = '0;
        {a_key, e_in, cin0, cin1, cin2, cin3, ref_lo, ref_hi} = '0;
        fail_count = 0;
        n_tests = 0;
        do_reset(1'b0, 1'b1, 1'b0, `NIBIO_DIV_SEL_1);
        t_reset_levels;
        t_nibble;
        t_bitops;
        t_tests;
        t_halt;
        t_second_reset;
        t_div_four;
        end_sim;
    end
endmodule

`default_nettype wire
